/* include/esm_regs.vh */
`ifndef ESM_REGS_VH
`define ESM_REGS_VH

// Register byte offsets
`define ESM_CORE_OFS     8'h8C
`define ESM_MISC_OFS     8'h90
`define ESM_PCIE_OFS     8'h94
`define ESM_THERM_OFS    8'h98
`define ESM_ADDR_W       8

// Severity codes
`define ESM_SEV_COR      2'h0
`define ESM_SEV_REC      2'h1
`define ESM_SEV_FAT      2'h2
`define ESM_SEV_RSV      2'h3

// Thermal route codes
`define ESM_RT_ALERT     2'h1
`define ESM_RT_TRIP      2'h2

// Writable bit masks
`define ESM_CORE_MASK    32'h00003F00
`define ESM_MISC_MASK    32'h000000FF
`define ESM_PCIE_MASK    32'h0000003F
`define ESM_THERM_MASK   32'h0000FFFF

// Power-good defaults
`define ESM_CORE_RST     32'h00001500
`define ESM_MISC_RST     32'h00000000
`define ESM_PCIE_RST     32'h00000024
`define ESM_THERM_RST    32'h00000804

// Field low bit positions
`define ESM_CORE_FIFO    5'h0C
`define ESM_CORE_CA      5'h0A
`define ESM_CORE_MA      5'h08
`define ESM_MISC_PAR     5'h00
`define ESM_MISC_SMB     5'h02
`define ESM_MISC_JTAG    5'h04
`define ESM_MISC_VR      5'h06
`define ESM_PCIE_FAT     5'h04
`define ESM_PCIE_NF      5'h02
`define ESM_PCIE_COR     5'h00
`define ESM_TH_ALERT     5'h00
`define ESM_TH_MAX_TEMPERATURE_RECORD     5'h04
`define ESM_TH_CAT       5'h08
`define ESM_TH_THR       5'h0C
`define ESM_RT_OFS       5'h02

// Source indices on err_event
`define ESM_SRC_FIFO     0
`define ESM_SRC_CA       1
`define ESM_SRC_MA       2
`define ESM_SRC_PAR      3
`define ESM_SRC_SMB      4
`define ESM_SRC_JTAG     5
`define ESM_SRC_VR       6
`define ESM_SRC_PFAT     7
`define ESM_SRC_PNF      8
`define ESM_SRC_PCOR     9
`define ESM_SRC_TALERT   10
`define ESM_SRC_MAX_TEMPERATURE_RECORD    11
`define ESM_SRC_TCAT     12
`define ESM_SRC_THR      13
`define ESM_NSRC         14

// AXI responses
`define ESM_RESP_OKAY    2'h0
`define ESM_RESP_SLVERR  2'h2

`endif

/* design/esm_error_severity_map_bank.v */
`include "esm_regs.vh"

// How it works
// - Severity codes: 00 cor, 01 rec, 10 fatal
// - Severity registers reset only by power-good loss; bus and event output registers reset by aresetn
// - Software writes any severity field
// - Errors reported with currently held severity
// - Core bits 13:12 FIFO error, default recoverable
// - Core bits 11:10 completer abort, default recoverable
// - Core bits 9:8 master abort, default recoverable
// - Misc bits 1:0 config parity, default correctable
// - Misc SMBus, JTAG, regulator fields default correctable
// - PCIe fatal mapped by bits 5:4, default 2
// - PCIe non-fatal mapped by bits 3:2, default 1
// - PCIe correctable mapped by bits 1:0, default 0
// - Thermal nibble: severity low, route high
// - Thermal alert bits 3:0, default 0100
// - Max temperature update bits 7:4, default 0
// - Catastrophic thermal bits 11:8, default 1000
// - Throttling history bits 15:12, default 0
// - Mapped severity steers downstream system event
module esm_error_severity_map_bank (
  input  wire                    aclk,
  input  wire                    aresetn,
  input  wire                    power_good_in,
  input  wire [`ESM_ADDR_W-1:0]  s_axi_awaddr,
  input  wire [2:0]              s_axi_awprot,
  input  wire                    s_axi_awvalid,
  output wire                    s_axi_awready,
  input  wire [31:0]             s_axi_wdata,
  input  wire [3:0]              s_axi_wstrb,
  input  wire                    s_axi_wvalid,
  output wire                    s_axi_wready,
  output reg  [1:0]              s_axi_bresp,
  output reg                     s_axi_bvalid,
  input  wire                    s_axi_bready,
  input  wire [`ESM_ADDR_W-1:0]  s_axi_araddr,
  input  wire [2:0]              s_axi_arprot,
  input  wire                    s_axi_arvalid,
  output wire                    s_axi_arready,
  output reg  [31:0]             s_axi_rdata,
  output reg  [1:0]              s_axi_rresp,
  output reg                     s_axi_rvalid,
  input  wire                    s_axi_rready,
  input  wire [`ESM_NSRC-1:0]    err_event,
  output reg  [`ESM_NSRC-1:0]    sev_valid,
  output reg  [2*`ESM_NSRC-1:0]  sev_code,
  output reg                     thermal_alert_out_n,
  output reg                     thermal_trip_out_n
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function [31:0] esm_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  strb;
    input [31:0] mask;
    integer i;
    reg [31:0] m;
    begin
      m = 32'h00000000;
      for (i = 0; i < 4; i = i + 1) begin
        m[8*i +: 8] = {8{strb[i]}};
      end
      m = m & mask;
      esm_merge = (old_val & ~m) | (new_val & m);
    end
  endfunction

  function [1:0] esm_field;
    input [31:0] r;
    input [4:0]  lo;
    begin
      esm_field = r[lo +: 2];
    end
  endfunction

  function [1:0] esm_route;
    input [31:0] r;
    input [4:0]  lo;
    begin
      esm_route = r[lo + `ESM_RT_OFS +: 2];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Register storage

  reg  [31:0] core_error_severity_reg;
  reg  [31:0] misc_error_severity_reg;
  reg  [31:0] pcie_error_severity_map_reg;
  reg  [31:0] thermal_error_severity_reg;

  reg                    aw_held_reg;
  reg  [`ESM_ADDR_W-1:0] aw_addr_reg;
  reg                    w_held_reg;
  reg  [31:0]            w_data_reg;
  reg  [3:0]             w_strb_reg;

  wire                   wr_go;
  wire [`ESM_ADDR_W-1:0] wr_addr;
  wire                   rd_go;
  wire                   wr_hit;
  wire                   rd_hit;

  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  assign wr_go   = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign wr_addr = aw_addr_reg;
  assign rd_go   = s_axi_arvalid & s_axi_arready;

  function esm_hit;
    input [`ESM_ADDR_W-1:0] a;
    begin
      esm_hit = (a == `ESM_CORE_OFS) || (a == `ESM_MISC_OFS) ||
                (a == `ESM_PCIE_OFS) || (a == `ESM_THERM_OFS);
    end
  endfunction

  assign wr_hit = esm_hit(wr_addr);
  assign rd_hit = esm_hit(s_axi_araddr);

  ////////////////////////////////////////////////////////////////////////
  // Write channel capture

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= {`ESM_ADDR_W{1'b0}};
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_reg <= 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_reg <= 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ESM_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `ESM_RESP_OKAY : `ESM_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next register values on a bus write

  reg  [31:0] core_error_severity_next;
  reg  [31:0] misc_error_severity_next;
  reg  [31:0] pcie_error_severity_map_next;
  reg  [31:0] thermal_error_severity_next;

  always @* begin
    core_error_severity_next     = core_error_severity_reg;
    misc_error_severity_next     = misc_error_severity_reg;
    pcie_error_severity_map_next = pcie_error_severity_map_reg;
    thermal_error_severity_next  = thermal_error_severity_reg;
    if (wr_go) begin
      case (wr_addr)
        `ESM_CORE_OFS: begin
          core_error_severity_next = esm_merge(core_error_severity_reg,
            w_data_reg, w_strb_reg, `ESM_CORE_MASK);
        end
        `ESM_MISC_OFS: begin
          misc_error_severity_next = esm_merge(misc_error_severity_reg,
            w_data_reg, w_strb_reg, `ESM_MISC_MASK);
        end
        `ESM_PCIE_OFS: begin
          pcie_error_severity_map_next = esm_merge(pcie_error_severity_map_reg,
            w_data_reg, w_strb_reg, `ESM_PCIE_MASK);
        end
        `ESM_THERM_OFS: begin
          thermal_error_severity_next = esm_merge(thermal_error_severity_reg,
            w_data_reg, w_strb_reg, `ESM_THERM_MASK);
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky severity registers

  always @(posedge aclk) begin
    if (!power_good_in) begin
      core_error_severity_reg     <= `ESM_CORE_RST;
      misc_error_severity_reg     <= `ESM_MISC_RST;
      pcie_error_severity_map_reg <= `ESM_PCIE_RST;
      thermal_error_severity_reg  <= `ESM_THERM_RST;
    end else begin
      core_error_severity_reg     <= core_error_severity_next;
      misc_error_severity_reg     <= misc_error_severity_next;
      pcie_error_severity_map_reg <= pcie_error_severity_map_next;
      thermal_error_severity_reg  <= thermal_error_severity_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data selection

  wire [31:0] core_rd;
  wire [31:0] misc_rd;
  wire [31:0] pcie_rd;
  wire [31:0] therm_rd;

  assign core_rd  = core_error_severity_reg & `ESM_CORE_MASK;
  assign misc_rd  = misc_error_severity_reg & `ESM_MISC_MASK;
  assign pcie_rd  = pcie_error_severity_map_reg & `ESM_PCIE_MASK;
  assign therm_rd = thermal_error_severity_reg & `ESM_THERM_MASK;

  reg  [31:0] rd_data_next;
  reg  [1:0]  rd_resp_next;

  always @* begin
    rd_resp_next = rd_hit ? `ESM_RESP_OKAY : `ESM_RESP_SLVERR;
    case (s_axi_araddr)
      `ESM_CORE_OFS:  rd_data_next = core_rd;
      `ESM_MISC_OFS:  rd_data_next = misc_rd;
      `ESM_PCIE_OFS:  rd_data_next = pcie_rd;
      `ESM_THERM_OFS: rd_data_next = therm_rd;
      default:        rd_data_next = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `ESM_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= rd_resp_next;
      s_axi_rdata  <= rd_data_next;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Severity fields per source

  wire [1:0] sev_fifo;
  wire [1:0] sev_ca;
  wire [1:0] sev_ma;
  wire [1:0] sev_par;
  wire [1:0] sev_smb;
  wire [1:0] sev_jtag;
  wire [1:0] sev_vr;
  wire [1:0] sev_pfat;
  wire [1:0] sev_pnf;
  wire [1:0] sev_pcor;
  wire [1:0] sev_talert;
  wire [1:0] sev_max_temperature_record;
  wire [1:0] sev_tcat;
  wire [1:0] sev_thr;
  wire [1:0] rt_talert;
  wire [1:0] rt_max_temperature_record;
  wire [1:0] rt_tcat;
  wire [1:0] rt_thr;

  assign sev_fifo   = esm_field(core_error_severity_reg, `ESM_CORE_FIFO);
  assign sev_ca     = esm_field(core_error_severity_reg, `ESM_CORE_CA);
  assign sev_ma     = esm_field(core_error_severity_reg, `ESM_CORE_MA);
  assign sev_par    = esm_field(misc_error_severity_reg, `ESM_MISC_PAR);
  assign sev_smb    = esm_field(misc_error_severity_reg, `ESM_MISC_SMB);
  assign sev_jtag   = esm_field(misc_error_severity_reg, `ESM_MISC_JTAG);
  assign sev_vr     = esm_field(misc_error_severity_reg, `ESM_MISC_VR);
  assign sev_pfat   = esm_field(pcie_error_severity_map_reg, `ESM_PCIE_FAT);
  assign sev_pnf    = esm_field(pcie_error_severity_map_reg, `ESM_PCIE_NF);
  assign sev_pcor   = esm_field(pcie_error_severity_map_reg, `ESM_PCIE_COR);
  assign sev_talert = esm_field(thermal_error_severity_reg, `ESM_TH_ALERT);
  assign sev_max_temperature_record  = esm_field(thermal_error_severity_reg, `ESM_TH_MAX_TEMPERATURE_RECORD);
  assign sev_tcat   = esm_field(thermal_error_severity_reg, `ESM_TH_CAT);
  assign sev_thr    = esm_field(thermal_error_severity_reg, `ESM_TH_THR);
  assign rt_talert  = esm_route(thermal_error_severity_reg, `ESM_TH_ALERT);
  assign rt_max_temperature_record   = esm_route(thermal_error_severity_reg, `ESM_TH_MAX_TEMPERATURE_RECORD);
  assign rt_tcat    = esm_route(thermal_error_severity_reg, `ESM_TH_CAT);
  assign rt_thr     = esm_route(thermal_error_severity_reg, `ESM_TH_THR);

  ////////////////////////////////////////////////////////////////////////
  // Severity lookup per source

  reg [2*`ESM_NSRC-1:0] sev_map;
  reg                   alert_hit;
  reg                   trip_hit;

  always @* begin
    sev_map = {2*`ESM_NSRC{1'b0}};
    sev_map[2*`ESM_SRC_FIFO +: 2]   = sev_fifo;
    sev_map[2*`ESM_SRC_CA +: 2]     = sev_ca;
    sev_map[2*`ESM_SRC_MA +: 2]     = sev_ma;
    sev_map[2*`ESM_SRC_PAR +: 2]    = sev_par;
    sev_map[2*`ESM_SRC_SMB +: 2]    = sev_smb;
    sev_map[2*`ESM_SRC_JTAG +: 2]   = sev_jtag;
    sev_map[2*`ESM_SRC_VR +: 2]     = sev_vr;
    sev_map[2*`ESM_SRC_PFAT +: 2]   = sev_pfat;
    sev_map[2*`ESM_SRC_PNF +: 2]    = sev_pnf;
    sev_map[2*`ESM_SRC_PCOR +: 2]   = sev_pcor;
    sev_map[2*`ESM_SRC_TALERT +: 2] = sev_talert;
    sev_map[2*`ESM_SRC_MAX_TEMPERATURE_RECORD +: 2]  = sev_max_temperature_record;
    sev_map[2*`ESM_SRC_TCAT +: 2]   = sev_tcat;
    sev_map[2*`ESM_SRC_THR +: 2]    = sev_thr;
    alert_hit = 1'b0;
    trip_hit  = 1'b0;
    if (err_event[`ESM_SRC_TALERT]) begin
      alert_hit = alert_hit | (rt_talert == `ESM_RT_ALERT);
      trip_hit  = trip_hit | (rt_talert == `ESM_RT_TRIP);
    end
    if (err_event[`ESM_SRC_MAX_TEMPERATURE_RECORD]) begin
      alert_hit = alert_hit | (rt_max_temperature_record == `ESM_RT_ALERT);
      trip_hit  = trip_hit | (rt_max_temperature_record == `ESM_RT_TRIP);
    end
    if (err_event[`ESM_SRC_TCAT]) begin
      alert_hit = alert_hit | (rt_tcat == `ESM_RT_ALERT);
      trip_hit  = trip_hit | (rt_tcat == `ESM_RT_TRIP);
    end
    if (err_event[`ESM_SRC_THR]) begin
      alert_hit = alert_hit | (rt_thr == `ESM_RT_ALERT);
      trip_hit  = trip_hit | (rt_thr == `ESM_RT_TRIP);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event outputs

  always @(posedge aclk) begin
    if (!aresetn) begin
      sev_valid <= {`ESM_NSRC{1'b0}};
      sev_code  <= {2*`ESM_NSRC{1'b0}};
    end else begin
      sev_valid <= err_event;
      sev_code  <= sev_map;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      thermal_alert_out_n <= 1'b1;
      thermal_trip_out_n  <= 1'b1;
    end else begin
      thermal_alert_out_n <= ~alert_hit;
      thermal_trip_out_n  <= ~trip_hit;
    end
  end

endmodule

/* tb/esm_bank_assertions.sv */
`include "esm_regs.vh"
module esm_bank_assertions (
  input logic              aclk,
  input logic              aresetn,
  input logic              power_good_in,
  input logic [7:0]        s_axi_araddr,
  input logic              s_axi_arvalid,
  input logic              s_axi_arready,
  input logic [31:0]       s_axi_rdata,
  input logic [1:0]        s_axi_rresp,
  input logic              s_axi_rvalid,
  input logic              s_axi_rready,
  input logic              s_axi_awready,
  input logic              s_axi_wready,
  input logic              s_axi_bvalid,
  input logic              s_axi_bready,
  input logic [13:0]       err_event,
  input logic [13:0]       sev_valid,
  input logic [27:0]       sev_code,
  input logic              thermal_alert_out_n,
  input logic              thermal_trip_out_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ra_reg;
  always @(posedge aclk)
    if (s_axi_arvalid && s_axi_arready) ra_reg <= s_axi_araddr;
  function automatic logic [31:0] msk(input logic [7:0] a);
    case (a)
      `ESM_CORE_OFS: return `ESM_CORE_MASK;
      `ESM_MISC_OFS: return `ESM_MISC_MASK;
      `ESM_PCIE_OFS: return `ESM_PCIE_MASK;
      `ESM_THERM_OFS: return `ESM_THERM_MASK;
      default: return 32'h0;
    endcase
  endfunction
  ////////////////////////////////////////
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rd_taken; s_axi_arvalid && s_axi_arready; endsequence
  sequence rd_waits; s_axi_rvalid && !s_axi_rready; endsequence
  sequence pg_low2; !power_good_in ##1 !power_good_in; endsequence
  read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read not answered");
  read_stand_a: assert property (rd_waits |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  reserved_zero_a: assert property (s_axi_rvalid |-> (s_axi_rdata & ~msk(ra_reg)) == 0)
    else $error("reserved bits not zero");
  read_resp_a: assert property (s_axi_rvalid |-> s_axi_rresp ==
    (msk(ra_reg) == 0 ? `ESM_RESP_SLVERR : `ESM_RESP_OKAY)) else $error("bad read response");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response stuck");
  event_valid_a: assert property ($past(aresetn) |-> sev_valid == $past(err_event))
    else $error("severity strobe wrong");
  thermal_pins_a: assert property ($past(aresetn) && $past(err_event[13:10]) == 0
    |-> thermal_alert_out_n && thermal_trip_out_n) else $error("thermal pin without event");
  pg_default_a: assert property (pg_low2 |=> sev_code == 28'h0018015)
    else $error("defaults not loaded");
endmodule
bind esm_error_severity_map_bank esm_bank_assertions chk_u (.*);

/* tb/esm_err_src.sv */
`include "esm_regs.vh"
module esm_err_src (
  input  logic                   aclk,
  output logic [`ESM_NSRC-1:0]   err_event,
  input  logic [`ESM_NSRC-1:0]   sev_valid,
  input  logic [2*`ESM_NSRC-1:0] sev_code,
  input  logic                   thermal_alert_out_n,
  input  logic                   thermal_trip_out_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial err_event = '0;
  // One-cycle error pulse, result seen one cycle later
  task automatic fire(input int i, output logic [4:0] got);
    @(posedge aclk);
    err_event[i] <= 1'b1;
    @(posedge aclk);
    err_event[i] <= 1'b0;
    #1;
    got = {sev_valid[i], sev_code[2*i +: 2], thermal_alert_out_n, thermal_trip_out_n};
  endtask
endmodule

/* tb/esm_error_severity_map_bank_bench.sv */
`include "esm_regs.vh"
module esm_error_severity_map_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, power_good_in = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [`ESM_NSRC-1:0] err_event, sev_valid;
  logic [2*`ESM_NSRC-1:0] sev_code;
  logic thermal_alert_out_n, thermal_trip_out_n;
  int fails = 0, checks = 0;
  logic [31:0] rg [4];
  logic [7:0] ofs [4] = '{`ESM_CORE_OFS, `ESM_MISC_OFS, `ESM_PCIE_OFS, `ESM_THERM_OFS};
  int ri [14] = '{0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 3, 3, 3, 3};
  int lb [14] = '{12, 10, 8, 0, 2, 4, 6, 4, 2, 0, 0, 4, 8, 12};
  always #2 aclk = ~aclk;
  esm_error_severity_map_bank dut_u (.*);
  esm_err_src src_u (.*);
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
    chk("rdata", e, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic reg_all();
    for (int k = 0; k < 4; k++) rd(ofs[k], rg[k], `ESM_RESP_OKAY);
  endtask
  task automatic src_all();
    logic [4:0] got;
    logic [1:0] rt;
    for (int i = 0; i < `ESM_NSRC; i++) begin
      src_u.fire(i, got);
      rt = (ri[i] == 3) ? rg[3][lb[i] + 2 +: 2] : 2'h0;
      chk("event", {27'h1, rg[ri[i]][lb[i] +: 2], rt != 2'h1, rt != 2'h2}, {27'h0, got});
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    rg = '{`ESM_CORE_RST, `ESM_MISC_RST, `ESM_PCIE_RST, `ESM_THERM_RST};
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    power_good_in <= 1;
    reg_all();
    src_all();
    rd(8'hA0, 32'h0, `ESM_RESP_SLVERR);
    $display("test defaults done");
    rg = '{32'h00002100, 32'h00000064, 32'h00000012, 32'h00006192};
    for (int k = 0; k < 4; k++) wr(ofs[k], rg[k] | 32'hFFFF0000 | (k == 0 ? 32'hFF : 0), 4'hF,
                                   `ESM_RESP_OKAY);
    wr(8'h9C, 32'hFFFFFFFF, 4'hF, `ESM_RESP_SLVERR);
    reg_all();
    src_all();
    $display("test remap done");
    aresetn <= 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    reg_all();
    power_good_in <= 0;
    repeat (3) @(posedge aclk);
    power_good_in <= 1;
    rg = '{`ESM_CORE_RST, `ESM_MISC_RST, `ESM_PCIE_RST, `ESM_THERM_RST};
    wr(ofs[3], 32'hFFFFFFFF, 4'h1, `ESM_RESP_OKAY);
    rg[3] = {rg[3][31:8], 8'hFF};
    reg_all();
    $display("test sticky done");
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    end_of_test();
  end
endmodule
